//--- hdl/pwr_mode_ctrl.sv
// Purpose: Doze, idle and sleep control with interrupt flags and wake
// Assumes: Core pulses sleep, return_from_interrupt and irq entry during its active cycle
// Notes: Register data read back one cycle after the read strobe
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// How it works
// - Doze runs one CPU cycle per period
// - Peripherals keep full rate during doze
// - Fetch follows CPU cycles, peripheral cycles stop only in sleep
// - Without recovery, service runs at doze rate
// - Recovering interrupt clears doze enable
// - Prefetched instruction runs before vectoring
// - Return with doze-on-exit sets doze enable
// - Sleep instruction picks idle or sleep
// - Idle halts CPU, peripheral clocks run
// - Main-oscillator peripherals stop only in sleep
// - Any interrupt ends idle, idle bit kept
// - Idle-ending interrupt may clear doze enable
// - Watchdog wakes idle instead of resetting
// - Sleep entry clears watchdog, keeps it running if wdt_sleep_en
// - Sleep entry clears power-down, sets timeout
// - Sleep stops CPU and system clocks
// - Requested or forced oscillators run in sleep
// - Sleep aborts ADC unless on RC clock
// - Idle ports hold their drive in sleep
// - Flags set regardless of any enable
// - Channel flags set by hardware, software clears
// - Ratio field decodes 1:2 through 1:256
// - Watchdog cleared on every sleep wake
module pwr_mode_ctrl
  import pwr_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU sequencer
  input wire cpu_cmd_t cpu_cmd,
  output clk_gate_t clk_gate,
  output logic irq_req,
  output logic [1:0] pwr_mode,
  // Peripheral events, one bit per flag
  input wire logic [NUM_IRQ_REGS-1:0][7:0] irq_event,
  // Watchdog
  input wire logic wdt_timeout,
  input wire logic wdt_sleep_en,
  output logic wdt_clear,
  output logic wdt_run,
  output logic wdt_reset_req,
  // Oscillators
  input wire logic [NUM_OSC-1:0] osc_req,
  output logic [NUM_OSC-1:0] osc_run,
  output logic fosc_periph_en,
  // ADC
  output logic adc_enable,
  output logic adc_abort,
  // I/O ports
  input wire logic [NUM_PORTS-1:0] port_periph_active,
  output logic [NUM_PORTS-1:0] io_hold
);
  pwr_mode_t mode_q;
  pwr_mode_t mode_d;
  logic [7:0] doze_ctrl_q;
  logic [7:0] doze_ctrl_d;
  logic [7:0] osc_force_q;
  logic [7:0] status_q;
  logic [7:0] gic_q;
  logic [7:0] adc_ctrl_q;
  logic [7:0] pie_q [NUM_IRQ_REGS];
  logic [7:0] pir_q [NUM_IRQ_REGS];
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic wdt_clear_q;
  logic adc_abort_q;
  logic [NUM_IRQ_REGS-1:0] pend_vec;
  logic cpu_cycle_en;

  // Decoding
  wire running = (mode_q == MODE_RUN);
  wire in_idle = (mode_q == MODE_IDLE);
  wire in_sleep = (mode_q == MODE_SLEEP);
  wire idle_en = doze_ctrl_q[BIT_IDLE_EN];
  wire doze_en = doze_ctrl_q[BIT_DOZE_EN];
  wire recover_on_interrupt = doze_ctrl_q[BIT_ROI];
  wire doze_on_exit = doze_ctrl_q[BIT_DOE];
  wire [RATIO_W-1:0] ratio = doze_ctrl_q[RATIO_LSB +: RATIO_W];
  wire global_interrupt_enable = gic_q[BIT_GIE];
  wire adc_on = adc_ctrl_q[BIT_ADC_ON];
  wire adc_rc = adc_ctrl_q[BIT_ADC_RC];
  wire pending = |pend_vec;
  wire wr_doze = reg_wr & (reg_addr == ADDR_DOZE_CTRL);
  wire wr_osc = reg_wr & (reg_addr == ADDR_OSC_FORCE);
  wire wr_gic = reg_wr & (reg_addr == ADDR_GIC);
  wire wr_adc = reg_wr & (reg_addr == ADDR_ADC_CTRL);
  // A pending enabled flag turns the sleep instruction into a no-op
  wire sleep_req = cpu_cmd.sleep & running & ~pending;
  wire enter_idle = sleep_req & idle_en;
  wire enter_sleep = sleep_req & ~idle_en;
  wire wake_irq = ~running & pending;
  wire wake_wdt = ~running & wdt_timeout;
  wire wake = wake_irq | wake_wdt;
  // Only interrupt wakes from idle and interrupt entry may recover full speed
  wire roi_clear = recover_on_interrupt & doze_en & (cpu_cmd.irq_entry | (in_idle & wake_irq));
  wire doe_set = cpu_cmd.return_from_interrupt & doze_on_exit;

  // Request flags and enables per register
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ_REGS; gi++) begin : g_irq
      localparam logic [7:0] MASK = irq_mask(gi);
      wire wr_pie = reg_wr & (reg_addr == ADDR_PERIPHERAL_INTERRUPT_ENABLE_0 + 4'(gi));
      wire wr_pir = reg_wr & (reg_addr == ADDR_PERIPHERAL_INTERRUPT_REQUEST_0 + 4'(gi));
      // Hardware set wins over a software clear in the same cycle
      wire [7:0] pir_d = ((wr_pir ? reg_wdata : pir_q[gi]) | irq_event[gi]) & MASK;
      assign pend_vec[gi] = |(pie_q[gi] & pir_q[gi]);

      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          pie_q[gi] <= IRQ_RST;
          pir_q[gi] <= IRQ_RST;
        end else if (clk_en) begin
          pir_q[gi] <= pir_d;
          if (wr_pie) begin
            pie_q[gi] <= reg_wdata & MASK;
          end
        end
      end
    end
  endgenerate

  // Hardware doze changes override a same-cycle software write
  always_comb begin
    doze_ctrl_d = wr_doze ? (reg_wdata & DOZE_CTRL_MASK) : doze_ctrl_q;
    if (roi_clear) begin
      doze_ctrl_d[BIT_DOZE_EN] = 1'b0;
    end else if (doe_set) begin
      doze_ctrl_d[BIT_DOZE_EN] = 1'b1;
    end
  end

  always_comb begin
    case (mode_q)
      MODE_RUN: begin
        mode_d = enter_idle ? MODE_IDLE : enter_sleep ? MODE_SLEEP : MODE_RUN;
      end
      MODE_IDLE: begin
        mode_d = wake ? MODE_RUN : MODE_IDLE;
      end
      MODE_SLEEP: begin
        mode_d = wake ? MODE_RUN : MODE_SLEEP;
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  always_comb begin
    case (reg_addr)
      ADDR_DOZE_CTRL: rd_mux = doze_ctrl_q;
      ADDR_OSC_FORCE: rd_mux = osc_force_q;
      ADDR_STATUS: rd_mux = status_q;
      ADDR_GIC: rd_mux = gic_q;
      ADDR_ADC_CTRL: rd_mux = adc_ctrl_q;
      default: begin
        if (reg_addr >= ADDR_PERIPHERAL_INTERRUPT_ENABLE_0 && reg_addr < ADDR_PERIPHERAL_INTERRUPT_REQUEST_0) begin
          rd_mux = pie_q[3'(reg_addr - ADDR_PERIPHERAL_INTERRUPT_ENABLE_0)];
        end else if (reg_addr >= ADDR_PERIPHERAL_INTERRUPT_REQUEST_0 && reg_addr < ADDR_PERIPHERAL_INTERRUPT_REQUEST_0 + 4'h5) begin
          rd_mux = pir_q[3'(reg_addr - ADDR_PERIPHERAL_INTERRUPT_REQUEST_0)];
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_q <= MODE_RUN;
      doze_ctrl_q <= DOZE_CTRL_RST;
    end else if (clk_en) begin
      mode_q <= mode_d;
      doze_ctrl_q <= doze_ctrl_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      osc_force_q <= OSC_FORCE_RST;
      gic_q <= GIC_RST;
      adc_ctrl_q <= ADC_CTRL_RST;
    end else if (clk_en) begin
      if (wr_osc) begin
        osc_force_q <= reg_wdata & 8'h07;
      end
      if (wr_gic) begin
        gic_q <= reg_wdata & GIC_MASK;
      end
      // adc_on stays set through a sleep abort
      if (wr_adc) begin
        adc_ctrl_q <= reg_wdata & ADC_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_q <= STATUS_RST;
    end else if (clk_en && enter_sleep) begin
      status_q[BIT_POWER_DOWN] <= 1'b0;
      status_q[BIT_TIMEOUT] <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      wdt_clear_q <= 1'b0;
      adc_abort_q <= 1'b0;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      wdt_clear_q <= enter_sleep | (in_sleep & wake);
      adc_abort_q <= enter_sleep & adc_on & ~adc_rc;
    end
  end

  // CPU gating; a restart gives the vector a full-speed first cycle
  doze_gate u_doze_gate (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(running),
    .doze_on(doze_en),
    .ratio(ratio),
    .restart(roi_clear),
    .cycle_en(cpu_cycle_en)
  );

  // Without recovery, irq entry simply waits for the next doze cycle
  assign clk_gate.cpu_cycle_en = cpu_cycle_en & clk_en;
  assign clk_gate.fetch_en = cpu_cycle_en & clk_en;
  assign clk_gate.periph_cycle_en = ~in_sleep & clk_en;
  assign clk_gate.cpu_clk_en = running;
  assign clk_gate.sys_clk_en = ~in_sleep;
  assign fosc_periph_en = ~in_sleep;
  assign irq_req = pending & global_interrupt_enable & running;
  assign pwr_mode = mode_q;
  assign reg_rdata = rdata_q;
  assign wdt_clear = wdt_clear_q;
  assign wdt_run = ~in_sleep | wdt_sleep_en;
  assign wdt_reset_req = wdt_timeout & running;
  assign adc_enable = adc_on & ~(in_sleep & ~adc_rc);
  assign adc_abort = adc_abort_q;

  generate
    for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
      assign osc_run[gi] = ~in_sleep | osc_req[gi] | osc_force_q[gi];
    end
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign io_hold[gi] = in_sleep & ~port_periph_active[gi];
    end
  endgenerate

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_idle_entry_mode: assert property (
    clk_en && cpu_cmd.sleep && running && !pending && idle_en |=> mode_q == MODE_IDLE)
    else $error("sleep with idle enabled did not enter idle");

  chk_sleep_entry_status: assert property (
    clk_en && enter_sleep |=> !status_q[BIT_POWER_DOWN] && status_q[BIT_TIMEOUT] && in_sleep)
    else $error("sleep entry status bits wrong");

  chk_sleep_osc_gate: assert property (
    in_sleep && !osc_req[OSC_LF] && !osc_force_q[OSC_LF] |-> !osc_run[OSC_LF]
      && !clk_gate.sys_clk_en)
    else $error("idle oscillator left running in sleep");

  chk_roi_doze_clear: assert property (
    clk_en && cpu_cmd.irq_entry && recover_on_interrupt && doze_en |=> !doze_en ##0 cpu_cycle_en)
    else $error("recovering interrupt kept doze");

  chk_doe_doze_set: assert property (
    clk_en && cpu_cmd.return_from_interrupt && doze_on_exit && !roi_clear |=> doze_en)
    else $error("return with doze-on-exit did not set doze");

  chk_idle_wake_irq: assert property (
    clk_en && in_idle && pending |=> running && idle_en == $past(idle_en))
    else $error("interrupt did not end idle");

  chk_wdt_idle_wake: assert property (
    clk_en && in_idle && wdt_timeout && !pending |-> !wdt_reset_req
      ##1 running && doze_en == $past(doze_en))
    else $error("watchdog in idle reset or changed doze");

  chk_flag_hw_set: assert property (
    clk_en && |(irq_event[4]) |=> (pir_q[4] & $past(irq_event[4])) == $past(irq_event[4]))
    else $error("event did not set its flag");

  chk_sleep_wake_wdt: assert property (
    clk_en && in_sleep && wake |=> wdt_clear && running)
    else $error("sleep wake did not clear watchdog");
endmodule : pwr_mode_ctrl

//--- hdl/pwr_pkg.sv
// Purpose: Shared constants and types for power-saving mode control
// Assumes: Byte-wide register port, 4-bit register address
// Notes: Register addresses and bit positions are local choices
package pwr_pkg;
  // Register addresses
  localparam logic [3:0] ADDR_DOZE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_OSC_FORCE = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_GIC = 4'h3;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_ENABLE_0 = 4'h4;
  localparam logic [3:0] ADDR_PERIPHERAL_INTERRUPT_REQUEST_0 = 4'h9;
  localparam logic [3:0] ADDR_ADC_CTRL = 4'he;
  localparam int NUM_IRQ_REGS = 5;
  localparam int NUM_PORTS = 3;
  // doze_idle_control fields
  localparam int BIT_IDLE_EN = 7;
  localparam int BIT_DOZE_EN = 6;
  localparam int BIT_ROI = 5;
  localparam int BIT_DOE = 4;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam logic [7:0] DOZE_CTRL_MASK = 8'hf7;
  localparam logic [7:0] DOZE_CTRL_RST = 8'h00;
  // global_interrupt_control fields
  localparam int BIT_GIE = 7;
  localparam logic [7:0] GIC_MASK = 8'hc1;
  localparam logic [7:0] GIC_RST = 8'h00;
  // Status fields (read only)
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // oscillator_force_enables fields, index per oscillator
  localparam int OSC_HF = 0;
  localparam int OSC_LF = 1;
  localparam int OSC_SECONDARY_OSCILLATOR = 2;
  localparam int NUM_OSC = 3;
  localparam logic [7:0] OSC_FORCE_RST = 8'h00;
  // ADC control fields
  localparam int BIT_ADC_ON = 0;
  localparam int BIT_ADC_RC = 1;
  localparam logic [7:0] ADC_CTRL_MASK = 8'h03;
  localparam logic [7:0] ADC_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam int DOZE_CNT_W = 8;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_SLEEP = 2'b11
  } pwr_mode_t;

  typedef struct packed {
    logic sleep;
    logic return_from_interrupt;
    logic irq_entry;
  } cpu_cmd_t;

  typedef struct packed {
    logic cpu_cycle_en;
    logic fetch_en;
    logic periph_cycle_en;
    logic cpu_clk_en;
    logic sys_clk_en;
  } clk_gate_t;

  // Implemented bits of each request/enable register
  function automatic logic [7:0] irq_mask(input int idx);
    case (idx)
      0: irq_mask = 8'h31;
      2: irq_mask = 8'hf3;
      default: irq_mask = 8'hff;
    endcase
  endfunction : irq_mask

  // Last count of a doze period: 000 -> 1 (1:2) ... 111 -> 255 (1:256)
  function automatic logic [DOZE_CNT_W-1:0] doze_last(input logic [RATIO_W-1:0] r);
    logic [DOZE_CNT_W:0] n;
    n = (9'h002 << r) - 9'h001;
    doze_last = n[DOZE_CNT_W-1:0];
  endfunction : doze_last
endpackage : pwr_pkg

//--- hdl/doze_gate.sv
// Purpose: Doze cycle gate, one CPU cycle per selected period
// Assumes: Called from the power mode controller only
// Notes: Restart forces the next cycle to be active
`timescale 1ns/100ps
module doze_gate
  import pwr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic doze_on,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic restart,
  // Gate
  output logic cycle_en
);
  logic [DOZE_CNT_W-1:0] cnt_q;
  logic [DOZE_CNT_W-1:0] cnt_d;
  wire at_last = (cnt_q == doze_last(ratio));

  // One active cycle, then the rest of the period idle
  assign cycle_en = run & (~doze_on | (cnt_q == '0));
  assign cnt_d = (~doze_on | restart) ? '0 :
                 (!run) ? cnt_q :
                 at_last ? '0 : cnt_q + 8'h01;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  chk_doze_gap_after: assert property (@(posedge mclk) disable iff (!reset_n)
    cycle_en && doze_on && !restart && clk_en |=> !cycle_en || !doze_on)
    else $error("doze active cycle not followed by idle cycle");
endmodule : doze_gate

//--- verif/cpu_seq_model.sv
// Purpose: Behavioural CPU sequencer facing the power mode controller
// Assumes: Commands leave only in active CPU cycles
// Notes: Vector entry waits one active cycle for the prefetched op
`timescale 1ns/100ps
module cpu_seq_model
  import pwr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // From controller
  input wire clk_gate_t clk_gate,
  input wire logic irq_req,
  // From bench
  input wire logic want_sleep,
  input wire logic want_return_from_interrupt,
  // To controller
  output cpu_cmd_t cpu_cmd
);
  logic sleep_q;
  logic return_from_interrupt_q;
  logic served_q;
  logic [1:0] stage_q;
  wire logic act = clk_gate.cpu_cycle_en;
  assign cpu_cmd.sleep = sleep_q & act;
  assign cpu_cmd.return_from_interrupt = return_from_interrupt_q & act;
  assign cpu_cmd.irq_entry = (stage_q == 2'h2) & act;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
      return_from_interrupt_q <= 1'b0;
      served_q <= 1'b0;
      stage_q <= 2'h0;
    end else begin
      sleep_q <= want_sleep | (sleep_q & !act);
      return_from_interrupt_q <= want_return_from_interrupt | (return_from_interrupt_q & !act);
      // Prefetched instruction finishes before vectoring
      if (stage_q == 2'h0) begin
        if (irq_req && !served_q) stage_q <= 2'h1;
      end else if (act) begin
        stage_q <= (stage_q == 2'h1) ? 2'h2 : 2'h0;
      end
      // One entry per request, rearmed once the request drops
      served_q <= cpu_cmd.irq_entry | (served_q & irq_req);
    end
  end
endmodule : cpu_seq_model

//--- verif/power_saving_mode_control_test.sv
// Purpose: Self-checking bench for the power mode controller
// Assumes: Core model issues commands, bench drives registers and events
// Notes: Register image kept in an integer array beside the design
`timescale 1ns/100ps
module power_saving_mode_control_test
  import pwr_pkg::*;
;
  logic mclk, reset_n, clk_en, reg_wr, reg_rd, wdt_timeout, wdt_sleep_en;
  logic want_sleep, want_return_from_interrupt, irq_req, wdt_clear, wdt_run, wdt_reset_req;
  logic fosc_periph_en, adc_enable, adc_abort;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] pwr_mode;
  logic [NUM_OSC-1:0] osc_req, osc_run;
  logic [NUM_PORTS-1:0] port_periph_active, io_hold;
  logic [NUM_IRQ_REGS-1:0][7:0] irq_event;
  cpu_cmd_t cpu_cmd;
  clk_gate_t clk_gate;
  int n_errors, checks, cyc, pl, k;
  int m[16];
  logic [31:0] seed;

  pwr_mode_ctrl pwr_mode_ctrl_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_cmd(cpu_cmd), .clk_gate(clk_gate), .irq_req(irq_req),
    .pwr_mode(pwr_mode), .irq_event(irq_event), .wdt_timeout(wdt_timeout),
    .wdt_sleep_en(wdt_sleep_en), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
    .wdt_reset_req(wdt_reset_req), .osc_req(osc_req), .osc_run(osc_run),
    .fosc_periph_en(fosc_periph_en), .adc_enable(adc_enable), .adc_abort(adc_abort),
    .port_periph_active(port_periph_active), .io_hold(io_hold));
  cpu_seq_model cpu_seq_model_i (.mclk(mclk), .reset_n(reset_n), .clk_gate(clk_gate),
    .irq_req(irq_req), .want_sleep(want_sleep), .want_return_from_interrupt(want_return_from_interrupt),
    .cpu_cmd(cpu_cmd));

  function automatic logic [7:0] mk(input int a);
    case (a)
      0: mk = 8'hf7;
      1: mk = 8'h07;
      3: mk = 8'hc1;
      4, 9: mk = 8'h31;
      6, 11: mk = 8'hf3;
      5, 7, 8, 10, 12, 13: mk = 8'hff;
      14: mk = 8'h03;
      default: mk = 8'h00;
    endcase
  endfunction : mk
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a[3:0];
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (mk(a) != 8'h00) m[a] = int'(d & mk(a));
  endtask : wr
  task automatic rdc(input int a);
    @(posedge mclk);
    reg_addr <= a[3:0];
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, 16'(m[a]));
  endtask : rdc
  task automatic ev(input int r, input int b);
    @(posedge mclk);
    irq_event[r][b] <= 1'b1;
    @(posedge mclk);
    irq_event[r][b] <= 1'b0;
    m[9 + r] = m[9 + r] | (1 << b);
  endtask : ev
  task automatic cmd(input logic s);
    @(posedge mclk);
    want_sleep <= s;
    want_return_from_interrupt <= !s;
    @(posedge mclk);
    want_sleep <= 1'b0;
    want_return_from_interrupt <= 1'b0;
  endtask : cmd
  task automatic nexta(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (clk_gate.periph_cycle_en !== 1'b1) pl++;
      if (clk_gate.fetch_en !== clk_gate.cpu_cycle_en) pl++;
    end while (clk_gate.cpu_cycle_en !== 1'b1 && n < 600);
  endtask : nexta
  // Skip two active cycles so a counter restart cannot skew the count
  task automatic period(input int e);
    int n;
    pl = 0;
    #1;
    nexta(n);
    nexta(n);
    nexta(n);
    chk(16'(n), 16'(e));
    chk(16'(pl), 16'h0000);
  endtask : period
  task automatic waitmode(input logic [1:0] md);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pwr_mode !== md && n < 40);
    chk({14'h0000, pwr_mode}, {14'h0000, md});
  endtask : waitmode
  task automatic wdog(input logic e);
    @(posedge mclk);
    wdt_timeout <= 1'b1;
    #1;
    chk({15'h0000, wdt_reset_req}, {15'h0000, e});
    @(posedge mclk);
    wdt_timeout <= 1'b0;
  endtask : wdog
  task automatic results;
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      results;
    end
  end

  initial begin
    {reset_n, reg_wr, reg_rd, wdt_timeout, wdt_sleep_en, want_sleep, want_return_from_interrupt} = '0;
    clk_en = 1'b1;
    {reg_addr, reg_wdata, osc_req, port_periph_active, irq_event} = '0;
    {n_errors, checks, cyc} = '0;
    seed = 32'hc5a6;
    for (k = 0; k < 16; k++) m[k] = 0;
    m[2] = 32'h18;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, masks, read-only status, unmapped address
    for (k = 0; k < 16; k++) begin
      rdc(k);
      wr(k, rnd());
      rdc(k);
      wr(k, 8'h00);
    end
    // Frozen clock enable: write ignored, cycle enables held low
    clk_en <= 1'b0;
    wr(1, 8'h07);
    m[1] = 0;
    chk({14'h0000, clk_gate.cpu_cycle_en, clk_gate.periph_cycle_en}, 16'h0000);
    clk_en <= 1'b1;
    rdc(1);
    // Flags set with every enable and the global enable clear
    for (k = 0; k < 5; k++) ev(k, 0);
    for (k = 1; k < 4; k++) ev(4, k);
    chk({15'h0000, irq_req}, 16'h0000);
    for (k = 9; k < 14; k++) rdc(k);
    for (k = 9; k < 14; k++) wr(k, 8'h00);
    rdc(13);
    for (k = 0; k < 8; k++) begin
      wr(0, 8'h40 | k[7:0]);
      period(2 << k);
    end
    wr(13, 8'h00);
    wr(8, 8'h01);
    wr(3, 8'h80);
    wr(0, 8'h64);
    ev(4, 0);
    repeat (80) @(posedge mclk);
    m[0] = 32'h24;
    rdc(0);
    period(1);
    wr(13, 8'h00);
    wr(0, 8'h14);
    cmd(1'b0);
    repeat (80) @(posedge mclk);
    m[0] = 32'h54;
    rdc(0);
    ev(4, 0);
    repeat (80) @(posedge mclk);
    rdc(0);
    period(32);
    wr(13, 8'h00);
    wr(3, 8'h00);
    wr(8, 8'h00);
    wr(0, 8'h00);
    wr(14, 8'h01);
    wr(1, 8'h04);
    osc_req <= 3'b001;
    port_periph_active <= 3'b010;
    wdt_sleep_en <= 1'b1;
    cmd(1'b1);
    waitmode(MODE_SLEEP);
    chk({14'h0000, wdt_clear, wdt_run}, 16'h0003);
    chk({14'h0000, adc_abort, adc_enable}, 16'h0002);
    chk({14'h0000, clk_gate.sys_clk_en, clk_gate.cpu_clk_en}, 16'h0000);
    chk({15'h0000, fosc_periph_en}, 16'h0000);
    chk({13'h0000, osc_run}, 16'h0005);
    chk({13'h0000, io_hold}, 16'h0005);
    m[2] = 32'h10;
    rdc(2);
    rdc(14);
    wr(8, 8'h02);
    ev(4, 1);
    waitmode(MODE_RUN);
    chk({15'h0000, wdt_clear}, 16'h0001);
    wr(13, 8'h00);
    wr(8, 8'h00);
    wdog(1'b1);
    wr(0, 8'he4);
    cmd(1'b1);
    waitmode(MODE_IDLE);
    chk({12'h000, clk_gate.cpu_cycle_en, clk_gate.fetch_en, clk_gate.periph_cycle_en,
      clk_gate.sys_clk_en}, 16'h0003);
    chk({15'h0000, fosc_periph_en}, 16'h0001);
    wdog(1'b0);
    waitmode(MODE_RUN);
    rdc(0);
    cmd(1'b1);
    waitmode(MODE_IDLE);
    wr(8, 8'h01);
    ev(4, 0);
    waitmode(MODE_RUN);
    m[0] = 32'ha4;
    rdc(0);
    // Sleep with the ADC on its own RC clock, watchdog wake
    wr(13, 8'h00);
    wr(14, 8'h03);
    wr(0, 8'h00);
    cmd(1'b1);
    waitmode(MODE_SLEEP);
    chk({14'h0000, adc_abort, adc_enable}, 16'h0001);
    wdog(1'b0);
    waitmode(MODE_RUN);
    rdc(14);
    results;
  end
endmodule : power_saving_mode_control_test
